// ### sewt_defines.vh
`ifndef SEWT_DEFINES_VH
`define SEWT_DEFINES_VH
// Fixed upper nibble of the device address word; value is arbitrary.
`define SEWT_DEV_CODE      4'h5
`define SEWT_ADDR_W        13
`define SEWT_MEM_DEPTH     8192
`define SEWT_PAGE_BITS     5
`define SEWT_PAGE_COUNT    256
`define SEWT_PROT_TOP      2'h3
`define SEWT_CLK_MHZ       125
`define SEWT_TWR_US        5000
`define SEWT_TWR_CYC       (`SEWT_TWR_US * `SEWT_CLK_MHZ)
`endif

// ### sewt_master.sv
`timescale 1ns/1ps
module sewt_master (
  input  wire  clk_in,
  input  wire  sda_in,
  output logic scl_out = 1'b1,
  output logic pull_out = 1'b0
);
  // Waits a quarter of the 160 ns bus clock.
  task automatic qtr;
    repeat (5) @(negedge clk_in);
  endtask
  // Sends one bit and samples the line in clock high.
  task automatic bit_io(input logic b, output logic r);
    qtr();
    pull_out = !b;
    qtr();
    scl_out = 1'b1;
    qtr();
    r = sda_in;
    qtr();
    scl_out = 1'b0;
  endtask
  task automatic start;
    qtr();
    pull_out = 1'b0;
    qtr();
    scl_out = 1'b1;
    qtr();
    pull_out = 1'b1;
    qtr();
    scl_out = 1'b0;
  endtask
  task automatic stop;
    qtr();
    pull_out = 1'b1;
    qtr();
    scl_out = 1'b1;
    qtr();
    pull_out = 1'b0;
    qtr();
  endtask
  // Moves a word MSB first, then the ninth bit.
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ma, a);
  endtask
  task automatic recover;
    logic r;
    repeat (9) bit_io(1'b1, r);
    start();
  endtask
endmodule

// ### sewt_slave.v
// Functional notes
// - Sample on rising clock, shift after falling.
// - Data line only pulled low or released.
// - Three select pins must match address word.
// - Write protect blocks upper quarter writes.
// - Array is 256 pages of 32 bytes.
// - Thirteen-bit word address selects one byte.
// - Data changes only while clock low.
// - Data falling while clock high is start.
// - Data rising while clock high is stop.
// - Stop after read returns to standby.
// - Eight-bit words, acknowledge on ninth clock.
// - Standby at reset and after stop, once any write cycle ends.
// - Timed write starts at stop, lasts 5 ms.
// - Page writes up to 32 bytes, partial allowed.
// - Address word last bit selects read or write.
// - Match acknowledges, mismatch waits for the next start or stop.
// - No acknowledge while write cycle runs.
// - Page write increments low five bits only.
`timescale 1ns/1ps
`include "sewt_defines.vh"
module sewt_slave #(
  parameter TWR_CYCLES = `SEWT_TWR_CYC
) (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_out,
  input  wire [2:0] device_select_pins_in,
  input  wire       write_protect_in,
  output wire       busy_out,
  output wire       standby_out
);
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_DEV   = 6'h02;
  localparam [5:0] ST_WADDR = 6'h04;
  localparam [5:0] ST_WDATA = 6'h08;
  localparam [5:0] ST_READ  = 6'h10;
  localparam [5:0] ST_WAIT  = 6'h20;

  reg [7:0]  mem [0:`SEWT_MEM_DEPTH-1];
  reg [7:0]  page_buf [0:31];
  reg [31:0] page_vld_r;
  reg [1:0]  scl_s_r, sda_s_r;
  reg        scl_d_r, sda_d_r;
  reg [2:0]  sel_s1_r, sel_s2_r;
  reg [1:0]  wp_s_r;
  reg [5:0]  state_r;
  reg [3:0]  bit_cnt_r;
  reg [7:0]  shift_r;
  reg        ack_phase_r, drive_low_r, rd_r, addr_hi_r, master_ack_r;
  reg [12:0] addr_r;
  reg [12:0] page_base_r;
  reg        wr_run_r, wr_pend_r;
  reg [5:0]  wr_idx_r;
  reg [31:0] wr_cnt_r;
  wire scl = scl_s_r[1];
  wire sda = sda_s_r[1];
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_c = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_c  = scl & scl_d_r & ~sda_d_r & sda;
  wire [7:0] word_in = {shift_r[6:0], sda};

  // Upper quarter of the array is guarded when protect is high.
  function prot_hit;
    input [12:0] a;
    input        wp;
    begin
      prot_hit = wp & (a[12:11] == `SEWT_PROT_TOP);
    end
  endfunction

  // Open drain pad: only ever drives low.
  assign sda_out     = 1'b0;
  assign sda_oe_out  = drive_low_r;
  assign busy_out    = wr_run_r;
  assign standby_out = (state_r == ST_IDLE) & ~wr_run_r;

  // Two-stage synchronisers for the bus pins, then edge history.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      sel_s1_r <= 3'h0;
      sel_s2_r <= 3'h0;
      wp_s_r  <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      sel_s1_r <= device_select_pins_in;
      sel_s2_r <= sel_s1_r;
      wp_s_r  <= {wp_s_r[0], write_protect_in};
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // Self-timed commit of the page buffer into the array after stop.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_run_r <= 1'b0;
      wr_cnt_r <= 32'h0;
      wr_idx_r <= 6'h0;
    end
    else if (wr_pend_r & stop_c & ~wr_run_r)
    begin
      wr_run_r <= 1'b1;
      wr_cnt_r <= 32'h0;
      wr_idx_r <= 6'h0;
    end
    else if (wr_run_r)
    begin
      if (wr_idx_r < 6'h20)
      begin
        if (page_vld_r[wr_idx_r[4:0]] &&
            !prot_hit({page_base_r[12:5], wr_idx_r[4:0]}, wp_s_r[1]))
          mem[{page_base_r[12:5], wr_idx_r[4:0]}] <= page_buf[wr_idx_r[4:0]];
        wr_idx_r <= wr_idx_r + 6'h1;
      end
      wr_cnt_r <= wr_cnt_r + 32'h1;
      if (wr_cnt_r >= TWR_CYCLES - 1)
        wr_run_r <= 1'b0;
    end
  end

  // Bit-level protocol engine.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r      <= ST_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h0;
      ack_phase_r  <= 1'b0;
      drive_low_r  <= 1'b0;
      rd_r         <= 1'b0;
      addr_hi_r    <= 1'b0;
      master_ack_r <= 1'b0;
      addr_r       <= 13'h0;
      page_base_r  <= 13'h0;
      page_vld_r   <= 32'h0;
      wr_pend_r    <= 1'b0;
    end
    else if (start_c)
    begin
      state_r     <= ST_DEV;
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
      drive_low_r <= 1'b0;
      // A start during the timed write must not drop the page being committed.
      if (!wr_run_r)
        page_vld_r <= 32'h0;
      wr_pend_r   <= 1'b0;
    end
    else if (stop_c)
    begin
      state_r     <= ST_IDLE;
      drive_low_r <= 1'b0;
      wr_pend_r   <= 1'b0;
    end
    else if (scl_rise && state_r != ST_IDLE && state_r != ST_WAIT)
    begin
      // Sample inbound bits on the rising clock edge.
      if (ack_phase_r)
      begin
        if (state_r == ST_READ)
          master_ack_r <= ~sda;
      end
      else if (state_r != ST_READ)
      begin
        shift_r   <= word_in;
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == 4'h7)
        begin
          case (state_r)
            ST_DEV:
            begin
              if (word_in[7:4] == `SEWT_DEV_CODE &&
                  word_in[3:1] == sel_s2_r && !wr_run_r)
              begin
                rd_r      <= word_in[0];
                addr_hi_r <= 1'b1;
              end
              else
                state_r <= ST_WAIT;
            end
            ST_WADDR:
            begin
              if (addr_hi_r)
                addr_r[12:8] <= word_in[4:0];
              else
              begin
                addr_r[7:0] <= word_in;
                page_base_r <= {addr_r[12:8], word_in};
              end
            end
            ST_WDATA:
            begin
              page_buf[addr_r[4:0]]   <= word_in;
              page_vld_r[addr_r[4:0]] <= 1'b1;
              wr_pend_r               <= 1'b1;
              addr_r[4:0]             <= addr_r[4:0] + 5'h1;
            end
            default:
              state_r <= state_r;
          endcase
        end
      end
      else
        bit_cnt_r <= bit_cnt_r + 4'h1;
    end
    else if (scl_fall && state_r != ST_IDLE && state_r != ST_WAIT)
    begin
      // Outbound bits and acknowledge change after the falling edge.
      if (ack_phase_r)
      begin
        ack_phase_r <= 1'b0;
        bit_cnt_r   <= 4'h0;
        drive_low_r <= 1'b0;
        if (state_r == ST_DEV)
          state_r <= rd_r ? ST_READ : ST_WADDR;
        else if (state_r == ST_WADDR)
        begin
          addr_hi_r <= 1'b0;
          if (!addr_hi_r)
            state_r <= ST_WDATA;
        end
        if ((state_r == ST_DEV && rd_r) || (state_r == ST_READ && master_ack_r))
        begin
          shift_r     <= mem[addr_r];
          drive_low_r <= ~mem[addr_r][7];
          addr_r      <= addr_r + 13'h1;
          // The MSB is out now; eight rising edges later the word is done.
          bit_cnt_r   <= 4'h0;
        end
        else if (state_r == ST_READ)
          state_r <= ST_WAIT;
      end
      else if (bit_cnt_r == 4'h8)
      begin
        ack_phase_r <= 1'b1;
        drive_low_r <= (state_r != ST_READ);
      end
      else if (state_r == ST_READ)
      begin
        drive_low_r <= ~shift_r[7 - bit_cnt_r[2:0]];
      end
    end
  end
endmodule

// ### sewt_slave_props.sv
`timescale 1ns/1ps
module sewt_slave_props #(
  parameter TWR_CYCLES = 200
) (
  input wire       clk_in,
  input wire       rst_in,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_out,
  input wire [2:0] device_select_pins_in,
  input wire       write_protect_in,
  input wire       busy_out,
  input wire       standby_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int busy_cnt_r;
  // Counts how long the internal write cycle has run.
  always @(posedge clk_in or posedge rst_in)
    if (rst_in)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= busy_out ? busy_cnt_r + 1 : 0;
  // Output relations at the pins.
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_chg; $changed(sda_oe_out) |-> !scl_in && $past(!scl_in, 2); endproperty
  a_chg: assert property (p_chg) else $error("data moved in clock high");
  property p_stand; $rose(sda_oe_out) |-> sda_oe_out [*8]; endproperty
  a_stand: assert property (p_stand) else $error("low bit too short");
  property p_len; busy_cnt_r <= TWR_CYCLES + 1; endproperty
  a_len: assert property (p_len) else $error("write cycle too long");
  property p_bstart; $rose(busy_out) |-> scl_in && sda_in && !$past(sda_in, 8); endproperty
  a_bstart: assert property (p_bstart) else $error("write cycle not at stop");
  property p_nack; busy_out |-> !sda_oe_out; endproperty
  a_nack: assert property (p_nack) else $error("answer while busy");
  property p_bs; busy_out |-> !standby_out; endproperty
  a_bs: assert property (p_bs) else $error("standby while busy");
  property p_rel; standby_out |-> !sda_oe_out; endproperty
  a_rel: assert property (p_rel) else $error("data held in standby");
  property p_stop; scl_in && $rose(sda_in) |-> ##[1:8] (standby_out || busy_out); endproperty
  a_stop: assert property (p_stop) else $error("no standby after stop");
  c_busy: cover property ($rose(busy_out));
  c_ack: cover property ($rose(sda_oe_out));
  c_stby: cover property ($rose(standby_out));
endmodule
bind sewt_slave sewt_slave_props #(.TWR_CYCLES(TWR_CYCLES)) u_props (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
  .device_select_pins_in(device_select_pins_in),
  .write_protect_in(write_protect_in), .standby_out(standby_out));

// ### sewt_slave_tb.sv
`timescale 1ns/1ps
`include "sewt_defines.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module sewt_slave_tb;
  logic       clk_in = 0;
  logic       rst_in = 1;
  logic [2:0] sel = 3'h5;
  logic       wp = 0;
  logic       ack;
  logic [7:0] q [4];
  wire        scl, sda, oe, pull, busy, stby;
  int         miscompares = 0;
  int         n_compared = 0;
  int         cyc = 0;
  // The data line is pulled up unless someone pulls it low.
  assign sda = !(oe | pull);
  sewt_slave #(.TWR_CYCLES(400)) uut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe_out(oe), .device_select_pins_in(sel),
    .write_protect_in(wp), .busy_out(busy), .standby_out(stby));
  sewt_master m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .pull_out(pull));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic dev(input logic [2:0] s, input logic rw, output logic a);
    logic [7:0] d;
    m.xfer({`SEWT_DEV_CODE, s, rw}, 1'b1, d, a);
  endtask
  // Starts a write and loads the word address.
  task automatic seta(input logic [12:0] a);
    logic [7:0] d;
    m.start();
    dev(sel, 1'b0, ack);
    `CHK("dev ack", 1'b0, ack)
    m.xfer({3'h0, a[12:8]}, 1'b1, d, ack);
    m.xfer(a[7:0], 1'b1, d, ack);
    `CHK("addr ack", 1'b0, ack)
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] b, input int n, input logic p);
    logic [7:0] d;
    seta(a);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(b + 8'(i), 1'b1, d, ack);
      `CHK("data ack", 1'b0, ack)
    end
    m.stop();
    if (p)
    begin
      m.start();
      dev(sel, 1'b0, ack);
      `CHK("poll ack", 1'b1, ack)
      m.stop();
    end
    repeat (500) if (busy) @(negedge clk_in);
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic rd(input logic [12:0] a, input int n);
    seta(a);
    m.start();
    dev(sel, 1'b1, ack);
    `CHK("rd ack", 1'b0, ack)
    for (int i = 0; i < n; i++)
      m.xfer(8'hFF, 1'(i == n - 1), q[i], ack);
    m.stop();
    repeat (4) @(negedge clk_in);
    `CHK("standby", 1'b1, stby)
  endtask
  // A page write past the page end wraps to its start.
  task automatic t_page;
    wr(13'h0A1E, 8'h40, 4, 1'b1);
    rd(13'h0A1E, 2);
    `CHK("q0", 8'h40, q[0])
    `CHK("q1 tail", 8'h41, q[1])
    rd(13'h0A00, 2);
    `CHK("q0 wrap", 8'h42, q[0])
    `CHK("q1", 8'h43, q[1])
    $display("t_page done");
  endtask
  // Other select values get no answer.
  task automatic t_sel;
    for (int s = 0; s < 8; s++)
      if (3'(s) != sel)
      begin
        m.start();
        dev(3'(s), 1'b0, ack);
        `CHK("sel ack", 1'b1, ack)
        m.stop();
      end
    $display("t_sel done");
  endtask
  // Protection blocks the upper quarter only.
  task automatic t_wp;
    wr(13'h1800, 8'h5A, 1, 1'b0);
    wp = 1;
    wr(13'h1800, 8'hA5, 1, 1'b0);
    wr(13'h17FF, 8'hC3, 1, 1'b0);
    rd(13'h17FF, 2);
    `CHK("low q", 8'hC3, q[0])
    `CHK("high q", 8'h5A, q[1])
    $display("t_wp done");
  endtask
  initial
    forever #4 clk_in = ~clk_in;
  // Cuts a hang short.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_in);
    rst_in = 0;
    m.recover();
    t_page();
    t_sel();
    t_wp();
    finish_test();
  end
endmodule
